// ### core/cfg_regs_map.vh
// register map of the configuration status and option bank
// assumes an 8-bit byte address, one aligned 32-bit word each
`ifndef CFG_REGS_MAP_VH
`define CFG_REGS_MAP_VH
// byte offsets
`define OFS_STATUS     8'h00
`define OFS_WATCHDOG   8'h04
`define OFS_FRAME      8'h08
`define OFS_FLASH      8'h0c
`define OFS_UPSET_CTL  8'h10
`define OFS_UPSET_STS  8'h14
// status fields
`define ST_PR_OVER     29
`define ST_PR_ERR      28
`define ST_OVER_TEMP   27
`define ST_X32         26
`define ST_X16         25
`define ST_X8          24
`define ST_IPAR_HI     23
`define ST_IPAR_LO     22
`define ST_FALLBACK    21
`define ST_PLL_LOCK    19
`define ST_GWEN        18
`define ST_GRSN        17
`define ST_GOUTEN      16
`define ST_GLOGEN_FB   15
`define ST_GLOGEN      14
`define ST_DONE_PIN    13
`define ST_DONE        12
`define ST_INIT_PIN    11
`define ST_INIT_DONE   10
`define ST_MODE_HI     9
`define ST_MODE_LO     7
`define ST_WAKEDOWN    6
`define ST_WAKEUP      5
`define ST_TIMEOUT     4
`define ST_RBCRC       3
`define ST_AUTH        2
`define ST_CRC         1
`define ST_ID          0
// parallel width codes on the detect input
`define PW_X8          2'h1
`define PW_X16         2'h2
`define PW_X32         2'h3
// watchdog fields
`define WATCHDOG_USER_MODE_ENABLE     31
`define WATCHDOG_CONFIG_MODE_ENABLE      30
`define WD_VAL_HI      29
`define WD_VAL_LO      0
`define WD_VAL_RST     30'h3fffffff
// frame start fields and valid range
`define FR_TYPE_HI     26
`define FR_TYPE_LO     25
`define FR_REG_HI      24
`define FR_REG_LO      20
`define FR_COL_HI      17
`define FR_COL_LO      10
`define FR_FRM_HI      7
`define FR_FRM_LO      0
`define FR_TYPE_NONBRAM 2'h0
`define FR_TYPE_BRAM   2'h1
`define FR_REG_MAX     5'h0f
`define FR_COL_MAX     8'hc7
`define FR_FRM_MAX     8'h3f
// flash option fields
`define FL_EXT_CLK     31
`define FL_EDGE        30
`define FL_ADDR32      10
`define FL_BUS_HI      9
`define FL_BUS_LO      8
`define FL_OP_HI       7
`define FL_OP_LO       0
`define FL_OP_RST      8'h0b
// upset control and status fields
`define UC_DETECT      1
`define UC_RBCRC       0
`define US_DR_OVER     16
`define US_DR_ERR      15
`define US_IDX_HI      14
`define US_IDX_LO      3
`define US_DED         2
`define US_SEC         1
`define US_OVER        0
`endif

// ### core/sync2.v
// two flip-flop synchroniser for slow pin levels
// assumes the inputs are levels, not pulses
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter W = 1
) (
  input  wire         clk_in,
  input  wire         rst_b_in,
  input  wire [W-1:0] d_in,
  output reg  [W-1:0] q_out
);
  reg [W-1:0] meta;

  // first stage feeds only the second
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      meta  <= {W{1'b0}};
      q_out <= {W{1'b0}};
    end
    else
    begin
      meta  <= d_in;
      q_out <= meta;
    end
  end
endmodule
`default_nettype wire

// ### core/wdog_timer.v
// watchdog counter: pulses once when count reaches the limit
// assumes limit and enable come from registers on the same clock
`timescale 1ns/1ps
`default_nettype none
module wdog_timer (
  input  wire        clk_in,
  input  wire        rst_b_in,
  input  wire        enable_in,
  input  wire        kick_in,
  input  wire [29:0] limit_in,
  output reg         expire_out
);
  reg [29:0] count;

  // restart on kick or while disabled, so enabling starts fresh
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      count      <= 30'h0;
      expire_out <= 1'b0;
    end
    else
    begin
      expire_out <= 1'b0;
      if (!enable_in || kick_in)
        count <= 30'h0;
      else if (count >= limit_in)
      begin
        count      <= 30'h0;
        expire_out <= 1'b1;
      end
      else
        count <= count + 30'h1;
    end
  end
endmodule
`default_nettype wire

// ### core/config_status_option_regs.v
// configuration status, watchdog, frame start, flash option and
// upset registers behind a plain strobe port
// assumes status inputs come from logic on CLK_IN, except the
// done and init pins which are synchronised here
`timescale 1ns/1ps
`default_nettype none
`include "cfg_regs_map.vh"
module config_status_option_regs (
  input  wire        CLK_IN,
  input  wire        RST_B_IN,
  // register port
  input  wire [7:0]  ADDR_IN,
  input  wire [31:0] WDATA_IN,
  input  wire        WR_IN,
  input  wire        RD_IN,
  output reg  [31:0] RDATA_OUT,
  // configuration core state
  input  wire        PR_OVER_IN,
  input  wire        PR_ERR_IN,
  input  wire        OVER_TEMP_IN,
  input  wire [1:0]  PAR_WIDTH_IN,
  input  wire [1:0]  IPAR_WIDTH_IN,
  input  wire        FALLBACK_IN,
  input  wire        PLL_LOCK_IN,
  input  wire        GWEN_IN,
  input  wire        GRSN_IN,
  input  wire        GOUTEN_IN,
  input  wire        GLOGEN_FB_IN,
  input  wire        GLOGEN_IN,
  input  wire        DONE_PIN_IN,
  input  wire        WAKEUP_OK_IN,
  input  wire        INIT_FLAG_PIN_IN,
  input  wire        INIT_DONE_IN,
  input  wire [2:0]  MODE_IN,
  input  wire        WAKEDOWN_OVER_IN,
  input  wire        WAKEUP_OVER_IN,
  input  wire        RBCRC_ERR_IN,
  input  wire        AUTH_ERR_IN,
  input  wire        CRC_ERR_IN,
  input  wire        ID_ERR_IN,
  // watchdog
  input  wire        USER_MODE_IN,
  input  wire        WDOG_KICK_IN,
  output reg         WDOG_TIMEOUT_OUT,
  // frame start pointer
  output reg  [1:0]  FRAME_TYPE_OUT,
  output reg  [4:0]  FRAME_REGION_OUT,
  output reg  [7:0]  FRAME_COLUMN_OUT,
  output reg  [7:0]  FRAME_INDEX_OUT,
  // master flash options
  output reg         FLASH_EXT_CLK_OUT,
  output reg         FLASH_FALL_EDGE_OUT,
  output reg         FLASH_ADDR32_OUT,
  output reg  [1:0]  FLASH_BUS_WIDTH_OUT,
  output reg  [7:0]  FLASH_OPCODE_OUT,
  // upset control and results
  output reg         UPSET_DETECT_EN_OUT,
  output reg         UPSET_RBCRC_EN_OUT,
  input  wire        UPSET_DONE_IN,
  input  wire        UPSET_SEC_IN,
  input  wire        UPSET_DED_IN,
  input  wire [11:0] UPSET_INDEX_IN,
  input  wire        DR_OVER_IN,
  input  wire        DR_ERR_IN
);
  // watchdog fields
  reg         watchdog_user_mode_enable;
  reg         watchdog_config_mode_enable;
  reg  [29:0] watchdog_timeout_count;
  reg         timeout_flag;
  // captured status
  reg  [31:0] status_word;
  reg  [16:0] upset_word;
  // pin levels after two flops
  wire [1:0]  pin_sync;
  wire        wd_expire;
  wire        wd_enable;
  wire        wr_watchdog;
  wire        wr_frame;
  wire        frame_ok;
  reg  [31:0] next_rdata;
  reg         par_width_32_flag;
  reg         par_width_16_flag;
  reg         par_width_8_flag;

  // done and init pins come from outside the clock domain
  sync2 #(
    .W (2)
  ) u_pins (
    .clk_in   (CLK_IN),
    .rst_b_in (RST_B_IN),
    .d_in     ({DONE_PIN_IN, INIT_FLAG_PIN_IN}),
    .q_out    (pin_sync)
  );

  // width flags: exactly one set for a detected width
  always @*
  begin
    par_width_32_flag = (PAR_WIDTH_IN == `PW_X32);
    par_width_16_flag = (PAR_WIDTH_IN == `PW_X16);
    par_width_8_flag  = (PAR_WIDTH_IN == `PW_X8);
  end

  // status word snapshot, one cycle behind its sources, three behind the done and init pins
  always @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      status_word <= 32'h00000000;
    else
    begin
      status_word                 <= 32'h00000000;
      status_word[`ST_PR_OVER]    <= PR_OVER_IN;
      status_word[`ST_PR_ERR]     <= PR_ERR_IN;
      status_word[`ST_OVER_TEMP]  <= OVER_TEMP_IN;
      status_word[`ST_X32]        <= par_width_32_flag;
      status_word[`ST_X16]        <= par_width_16_flag;
      status_word[`ST_X8]         <= par_width_8_flag;
      status_word[`ST_IPAR_HI:`ST_IPAR_LO] <= IPAR_WIDTH_IN;
      status_word[`ST_FALLBACK]   <= FALLBACK_IN;
      status_word[`ST_PLL_LOCK]   <= PLL_LOCK_IN;
      status_word[`ST_GWEN]       <= GWEN_IN;
      status_word[`ST_GRSN]       <= GRSN_IN;
      status_word[`ST_GOUTEN]     <= GOUTEN_IN;
      status_word[`ST_GLOGEN_FB]  <= GLOGEN_FB_IN;
      status_word[`ST_GLOGEN]     <= GLOGEN_IN;
      status_word[`ST_DONE_PIN]   <= pin_sync[1];
      status_word[`ST_DONE]       <= WAKEUP_OK_IN;
      status_word[`ST_INIT_PIN]   <= pin_sync[0];
      status_word[`ST_INIT_DONE]  <= INIT_DONE_IN;
      status_word[`ST_MODE_HI:`ST_MODE_LO] <= MODE_IN;
      status_word[`ST_WAKEDOWN]   <= WAKEDOWN_OVER_IN;
      status_word[`ST_WAKEUP]     <= WAKEUP_OVER_IN;
      status_word[`ST_RBCRC]      <= RBCRC_ERR_IN;
      status_word[`ST_AUTH]       <= AUTH_ERR_IN;
      status_word[`ST_CRC]        <= CRC_ERR_IN;
      status_word[`ST_ID]         <= ID_ERR_IN;
    end
  end

  // the enable that matches the present mode drives the timer
  assign wd_enable = USER_MODE_IN ? watchdog_user_mode_enable
                                  : watchdog_config_mode_enable;
  assign wr_watchdog = WR_IN && (ADDR_IN == `OFS_WATCHDOG);

  // a write to the watchdog counts as service too
  wdog_timer u_wdog (
    .clk_in     (CLK_IN),
    .rst_b_in   (RST_B_IN),
    .enable_in  (wd_enable),
    .kick_in    (WDOG_KICK_IN || wr_watchdog),
    .limit_in   (watchdog_timeout_count),
    .expire_out (wd_expire)
  );

  // watchdog register
  always @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      watchdog_user_mode_enable   <= 1'b0;
      watchdog_config_mode_enable <= 1'b0;
      watchdog_timeout_count      <= `WD_VAL_RST;
    end
    else if (wr_watchdog)
    begin
      watchdog_user_mode_enable   <= WDATA_IN[`WATCHDOG_USER_MODE_ENABLE];
      watchdog_config_mode_enable <= WDATA_IN[`WATCHDOG_CONFIG_MODE_ENABLE];
      watchdog_timeout_count      <= WDATA_IN[`WD_VAL_HI:`WD_VAL_LO];
    end
  end

  // sticky timeout: a watchdog write clears it, expiry wins
  always @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      timeout_flag     <= 1'b0;
      WDOG_TIMEOUT_OUT <= 1'b0;
    end
    else
    begin
      if (wd_expire)
        timeout_flag <= 1'b1;
      else if (wr_watchdog)
        timeout_flag <= 1'b0;
      WDOG_TIMEOUT_OUT <= wd_expire;
    end
  end

  // range check; a bad word is dropped whole so the pointer
  // never names a frame that does not exist
  assign frame_ok =
    (WDATA_IN[`FR_REG_HI:`FR_REG_LO] <= `FR_REG_MAX) &&
    (WDATA_IN[`FR_COL_HI:`FR_COL_LO] <= `FR_COL_MAX) &&
    (WDATA_IN[`FR_FRM_HI:`FR_FRM_LO] <= `FR_FRM_MAX) &&
    !WDATA_IN[`FR_TYPE_HI];
  assign wr_frame = WR_IN && (ADDR_IN == `OFS_FRAME);

  // frame start pointer
  always @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      FRAME_TYPE_OUT   <= `FR_TYPE_NONBRAM;
      FRAME_REGION_OUT <= 5'h00;
      FRAME_COLUMN_OUT <= 8'h00;
      FRAME_INDEX_OUT  <= 8'h00;
    end
    else if (wr_frame && frame_ok)
    begin
      FRAME_TYPE_OUT   <= WDATA_IN[`FR_TYPE_HI:`FR_TYPE_LO];
      FRAME_REGION_OUT <= WDATA_IN[`FR_REG_HI:`FR_REG_LO];
      FRAME_COLUMN_OUT <= WDATA_IN[`FR_COL_HI:`FR_COL_LO];
      FRAME_INDEX_OUT  <= WDATA_IN[`FR_FRM_HI:`FR_FRM_LO];
    end
  end

  // master flash options
  always @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      FLASH_EXT_CLK_OUT   <= 1'b0;
      FLASH_FALL_EDGE_OUT <= 1'b0;
      FLASH_ADDR32_OUT    <= 1'b0;
      FLASH_BUS_WIDTH_OUT <= 2'h0;
      FLASH_OPCODE_OUT    <= `FL_OP_RST;
    end
    else if (WR_IN && (ADDR_IN == `OFS_FLASH))
    begin
      FLASH_EXT_CLK_OUT   <= WDATA_IN[`FL_EXT_CLK];
      FLASH_FALL_EDGE_OUT <= WDATA_IN[`FL_EDGE];
      FLASH_ADDR32_OUT    <= WDATA_IN[`FL_ADDR32];
      FLASH_BUS_WIDTH_OUT <= WDATA_IN[`FL_BUS_HI:`FL_BUS_LO];
      FLASH_OPCODE_OUT    <= WDATA_IN[`FL_OP_HI:`FL_OP_LO];
    end
  end

  // upset control
  always @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      UPSET_DETECT_EN_OUT <= 1'b0;
      UPSET_RBCRC_EN_OUT  <= 1'b0;
    end
    else if (WR_IN && (ADDR_IN == `OFS_UPSET_CTL))
    begin
      UPSET_DETECT_EN_OUT <= WDATA_IN[`UC_DETECT];
      UPSET_RBCRC_EN_OUT  <= WDATA_IN[`UC_RBCRC];
    end
  end

  // upset results; index only moves on a single-bit upset so
  // software still sees the last position after a clean pass
  always @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      upset_word <= 17'h00000;
    else
    begin
      upset_word[`US_DR_OVER] <= DR_OVER_IN;
      upset_word[`US_DR_ERR]  <= DR_ERR_IN;
      upset_word[`US_DED]     <= UPSET_DED_IN;
      upset_word[`US_SEC]     <= UPSET_SEC_IN;
      upset_word[`US_OVER]    <= UPSET_DONE_IN;
      if (UPSET_SEC_IN)
        upset_word[`US_IDX_HI:`US_IDX_LO] <= UPSET_INDEX_IN;
    end
  end

  // read mux; unmapped words and reserved bits read zero
  always @*
  begin
    next_rdata = 32'h00000000;
    case (ADDR_IN)
      `OFS_STATUS:
      begin
        next_rdata = status_word;
        next_rdata[`ST_TIMEOUT] = timeout_flag;
      end
      `OFS_WATCHDOG:
        next_rdata = {watchdog_user_mode_enable,
                      watchdog_config_mode_enable,
                      watchdog_timeout_count};
      `OFS_FRAME:
        next_rdata = {5'h00, FRAME_TYPE_OUT, FRAME_REGION_OUT,
                      2'h0, FRAME_COLUMN_OUT, 2'h0,
                      FRAME_INDEX_OUT};
      `OFS_FLASH:
        next_rdata = {FLASH_EXT_CLK_OUT, FLASH_FALL_EDGE_OUT,
                      19'h00000, FLASH_ADDR32_OUT,
                      FLASH_BUS_WIDTH_OUT, FLASH_OPCODE_OUT};
      `OFS_UPSET_CTL:
        next_rdata = {30'h00000000, UPSET_DETECT_EN_OUT,
                      UPSET_RBCRC_EN_OUT};
      `OFS_UPSET_STS:
        next_rdata = {15'h0000, upset_word};
      default:
        next_rdata = 32'h00000000;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      RDATA_OUT <= 32'h00000000;
    else if (RD_IN)
      RDATA_OUT <= next_rdata;
    else
      RDATA_OUT <= 32'h00000000;
  end
endmodule
`default_nettype wire

// ### sim/cfg_regs_assertions.sv
// assertions for the configuration status and option register bank
// assumes a bind onto config_status_option_regs, ports named alike
`timescale 1ns/1ps
`default_nettype none
`include "cfg_regs_map.vh"
module cfg_regs_checker (
  input wire logic        CLK_IN,
  input wire logic        RST_B_IN,
  input wire logic [7:0]  ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic        WR_IN,
  input wire logic        RD_IN,
  input wire logic [31:0] RDATA_OUT,
  input wire logic        PR_OVER_IN,
  input wire logic        GWEN_IN,
  input wire logic        AUTH_ERR_IN,
  input wire logic        WDOG_TIMEOUT_OUT,
  input wire logic [1:0]  FRAME_TYPE_OUT,
  input wire logic [4:0]  FRAME_REGION_OUT,
  input wire logic [7:0]  FRAME_COLUMN_OUT,
  input wire logic [7:0]  FRAME_INDEX_OUT,
  input wire logic        FLASH_EXT_CLK_OUT,
  input wire logic        FLASH_FALL_EDGE_OUT,
  input wire logic        FLASH_ADDR32_OUT,
  input wire logic [1:0]  FLASH_BUS_WIDTH_OUT,
  input wire logic [7:0]  FLASH_OPCODE_OUT,
  input wire logic        UPSET_DETECT_EN_OUT,
  input wire logic        UPSET_RBCRC_EN_OUT,
  input wire logic        UPSET_DONE_IN,
  input wire logic        UPSET_SEC_IN,
  input wire logic        UPSET_DED_IN,
  input wire logic        DR_OVER_IN,
  input wire logic        DR_ERR_IN
);
  // register images of the output fields, reserved bits zero
  wire [31:0] fr = {5'h0, FRAME_TYPE_OUT, FRAME_REGION_OUT, 2'h0,
                    FRAME_COLUMN_OUT, 2'h0, FRAME_INDEX_OUT};
  wire [31:0] fl = {FLASH_EXT_CLK_OUT, FLASH_FALL_EDGE_OUT, 19'h0,
                    FLASH_ADDR32_OUT, FLASH_BUS_WIDTH_OUT, FLASH_OPCODE_OUT};
  wire fr_ok = !WDATA_IN[26] && WDATA_IN[24:20] <= `FR_REG_MAX &&
               WDATA_IN[17:10] <= `FR_COL_MAX &&
               WDATA_IN[7:0] <= `FR_FRM_MAX;
  wire fr_wr = WR_IN && ADDR_IN == `OFS_FRAME;
  wire fl_wr = WR_IN && ADDR_IN == `OFS_FLASH;
  wire [2:0] sv = {PR_OVER_IN, GWEN_IN, AUTH_ERR_IN};
  wire [4:0] uv = {DR_OVER_IN, DR_ERR_IN, UPSET_DED_IN, UPSET_SEC_IN,
                   UPSET_DONE_IN};
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  // a long or disabled limit leaves no room for an early expiry
  sequence wd_slow_wr;
    WR_IN && ADDR_IN == `OFS_WATCHDOG &&
    (WDATA_IN[31:30] == 2'h0 || WDATA_IN[29:0] >= 30'h8);
  endsequence
  sequence wd_quiet;
    !WDOG_TIMEOUT_OUT [*8];
  endsequence
  rd_idle_a: assert property (!RD_IN |=> RDATA_OUT == 32'h0)
    else $error("read data not zero outside a read");
  status_read_a: assert property (
    RD_IN && ADDR_IN == `OFS_STATUS && $stable(sv) |=>
    {RDATA_OUT[29], RDATA_OUT[18], RDATA_OUT[2]} == $past(sv))
    else $error("status word does not follow its inputs");
  upset_read_a: assert property (
    RD_IN && ADDR_IN == `OFS_UPSET_STS && $stable(uv) |=>
    {RDATA_OUT[16:15], RDATA_OUT[2:0]} == $past(uv))
    else $error("upset status does not follow its inputs");
  frame_load_a: assert property (fr_wr && fr_ok |=>
    fr == $past(WDATA_IN & 32'h07f3fcff))
    else $error("frame pointer not loaded");
  frame_drop_a: assert property (fr_wr && !fr_ok |=> $stable(fr))
    else $error("out of range frame pointer accepted");
  flash_load_a: assert property (fl_wr |=>
    fl == $past(WDATA_IN & 32'hc00007ff))
    else $error("flash options not loaded");
  flash_hold_a: assert property (!fl_wr |=> $stable(fl))
    else $error("flash options changed without a write");
  upset_ctl_a: assert property (WR_IN && ADDR_IN == `OFS_UPSET_CTL |=>
    {UPSET_DETECT_EN_OUT, UPSET_RBCRC_EN_OUT} == $past(WDATA_IN[1:0]))
    else $error("upset enables not loaded");
  wd_quiet_a: assert property (wd_slow_wr |-> ##2 wd_quiet)
    else $error("watchdog expired too early");
endmodule
bind config_status_option_regs cfg_regs_checker cfg_regs_checker_inst (.*);
`default_nettype wire

// ### sim/config_status_option_regs_tb.sv
// self-checking bench for the configuration register bank
// assumes the checker file is compiled alongside and core/ included
`timescale 1ns/1ps
`default_nettype none
`include "cfg_regs_map.vh"
module config_status_option_regs_tb;
  logic CLK_IN, RST_B_IN, WR_IN, RD_IN, PR_OVER_IN, PR_ERR_IN, GWEN_IN;
  logic OVER_TEMP_IN, FALLBACK_IN, PLL_LOCK_IN, GRSN_IN, GOUTEN_IN;
  logic GLOGEN_FB_IN, GLOGEN_IN, DONE_PIN_IN, WAKEUP_OK_IN, ID_ERR_IN;
  logic INIT_FLAG_PIN_IN, INIT_DONE_IN, WAKEDOWN_OVER_IN, WAKEUP_OVER_IN;
  logic RBCRC_ERR_IN, AUTH_ERR_IN, CRC_ERR_IN, USER_MODE_IN, WDOG_KICK_IN;
  logic UPSET_DONE_IN, UPSET_SEC_IN, UPSET_DED_IN, DR_OVER_IN, DR_ERR_IN;
  logic [1:0]  PAR_WIDTH_IN, IPAR_WIDTH_IN, FRAME_TYPE_OUT;
  logic [2:0]  MODE_IN;
  logic [11:0] UPSET_INDEX_IN;
  logic [7:0]  ADDR_IN, FRAME_COLUMN_OUT, FRAME_INDEX_OUT, FLASH_OPCODE_OUT;
  logic [31:0] WDATA_IN, RDATA_OUT;
  logic        WDOG_TIMEOUT_OUT, FLASH_EXT_CLK_OUT, FLASH_FALL_EDGE_OUT;
  logic        FLASH_ADDR32_OUT, UPSET_DETECT_EN_OUT, UPSET_RBCRC_EN_OUT;
  logic [4:0]  FRAME_REGION_OUT;
  logic [1:0]  FLASH_BUS_WIDTH_OUT;
  int bad_count = 0, checked = 0, cyc = 0, pulses = 0;
  // address, write data, expected read back
  logic [71:0] rows [14] = '{
    {8'h04, 32'h00000123, 32'h00000123},
    {8'h08, 32'h02f31c3f, 32'h02f31c3f},
    {8'h08, 32'h04000000, 32'h02f31c3f},
    {8'h08, 32'h01000000, 32'h02f31c3f},
    {8'h08, 32'h00032000, 32'h02f31c3f},
    {8'h08, 32'h00000040, 32'h02f31c3f},
    {8'h08, 32'h00000000, 32'h00000000},
    {8'h0c, 32'hc00007a5, 32'hc00007a5},
    {8'h0c, 32'h0000010b, 32'h0000010b},
    {8'h0c, 32'h0000020b, 32'h0000020b},
    {8'h0c, 32'h0000000b, 32'h0000000b},
    {8'h10, 32'h00000003, 32'h00000003},
    {8'h10, 32'h00000002, 32'h00000002},
    {8'h18, 32'hffffffff, 32'h00000000}};
  // status words to present: x32, x16, x8 and idle
  logic [31:0] sw [4] = '{32'h3cefffef, 32'h02000000, 32'h01000000, 0};
  config_status_option_regs config_status_option_regs_inst (.*);

  initial
  begin
    CLK_IN = 0;
    forever #5 CLK_IN = ~CLK_IN;
  end
  // timeout guard and watchdog pulse tally
  always @(posedge CLK_IN)
  begin
    cyc <= cyc + 1;
    if (WDOG_TIMEOUT_OUT === 1'b1) pulses <= pulses + 1;
    if (cyc == 2000)
    begin
      bad_count++;
      test_done();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_IN);
    ADDR_IN <= a;
    WDATA_IN <= d;
    WR_IN <= 1;
    @(posedge CLK_IN);
    WR_IN <= 0;
  endtask
  // read data stands only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge CLK_IN);
    ADDR_IN <= a;
    RD_IN <= 1;
    @(posedge CLK_IN);
    RD_IN <= 0;
    #1 chk(RDATA_OUT, e);
  endtask
  task set_st(input logic [31:0] w);
    {PR_OVER_IN, PR_ERR_IN, OVER_TEMP_IN} <= w[29:27];
    PAR_WIDTH_IN <= w[26] ? `PW_X32 : w[25] ? `PW_X16 : {1'b0, w[24]};
    {IPAR_WIDTH_IN, FALLBACK_IN} <= w[23:21];
    {PLL_LOCK_IN, GWEN_IN, GRSN_IN, GOUTEN_IN, GLOGEN_FB_IN, GLOGEN_IN,
     DONE_PIN_IN, WAKEUP_OK_IN, INIT_FLAG_PIN_IN, INIT_DONE_IN, MODE_IN,
     WAKEDOWN_OVER_IN, WAKEUP_OVER_IN} <= w[19:5];
    {RBCRC_ERR_IN, AUTH_ERR_IN, CRC_ERR_IN, ID_ERR_IN} <= w[3:0];
  endtask
  task set_up(input logic [16:0] u);
    {DR_OVER_IN, DR_ERR_IN, UPSET_INDEX_IN, UPSET_DED_IN, UPSET_SEC_IN,
     UPSET_DONE_IN} <= u;
  endtask
  task rst_chk;
    rd(`OFS_WATCHDOG, 32'h3fffffff);
    rd(`OFS_FRAME, 32'h0);
    rd(`OFS_FLASH, 32'h0000000b);
    rd(`OFS_UPSET_CTL, 32'h0);
  endtask
  // skip two edges so a pulse left from the last setting is not counted
  task wd_run(input logic [31:0] d, input logic m, k, e);
    int p;
    wr(`OFS_WATCHDOG, d);
    USER_MODE_IN <= m;
    repeat (2) @(posedge CLK_IN);
    p = pulses;
    repeat (10)
    begin
      WDOG_KICK_IN <= k;
      @(posedge CLK_IN);
      WDOG_KICK_IN <= 0;
      repeat (2) @(posedge CLK_IN);
    end
    chk(pulses > p, e);
  endtask
  task test_done;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    {RST_B_IN, ADDR_IN, WDATA_IN, WR_IN, RD_IN} = 0;
    {USER_MODE_IN, WDOG_KICK_IN} = 0;
    set_st(0);
    set_up(0);
    repeat (8) @(posedge CLK_IN);
    RST_B_IN <= 1;
    rst_chk();
    $display("reset values done");
    foreach (rows[i])
    begin
      wr(rows[i][71:64], rows[i][63:32]);
      rd(rows[i][71:64], rows[i][31:0]);
    end
    $display("register rows done");
    // writes to the status word must not disturb it
    foreach (sw[i])
    begin
      @(posedge CLK_IN);
      set_st(sw[i]);
      wr(`OFS_STATUS, ~sw[i]);
      repeat (3) @(posedge CLK_IN);
      rd(`OFS_STATUS, sw[i]);
    end
    $display("status done");
    @(posedge CLK_IN);
    set_up(17'h155e7);
    repeat (3) @(posedge CLK_IN);
    rd(`OFS_UPSET_STS, 32'h000155e7);
    @(posedge CLK_IN);
    set_up(17'h08918);
    wr(`OFS_UPSET_STS, 32'hffffffff);
    rd(`OFS_UPSET_STS, 32'h0000d5e0);
    @(posedge CLK_IN);
    set_up(0);
    $display("upset status done");
    wd_run(32'h40000005, 1, 0, 0);
    wd_run(32'h40000005, 0, 0, 1);
    wd_run(32'h80000005, 0, 0, 0);
    wd_run(32'h80000005, 1, 1, 0);
    wd_run(32'h80000005, 1, 0, 1);
    rd(`OFS_STATUS, 32'h00000010);
    wr(`OFS_WATCHDOG, 32'h5);
    wr(`OFS_WATCHDOG, 32'h5);
    rd(`OFS_STATUS, 32'h0);
    $display("watchdog done");
    wr(`OFS_FLASH, 32'hc00007a5);
    wr(`OFS_UPSET_CTL, 32'h3);
    #1 chk({FLASH_EXT_CLK_OUT, FLASH_FALL_EDGE_OUT, FLASH_ADDR32_OUT,
      FLASH_BUS_WIDTH_OUT, FLASH_OPCODE_OUT, UPSET_DETECT_EN_OUT,
      UPSET_RBCRC_EN_OUT}, 32'h7e97);
    // reset lands just after an edge: only an asynchronous clear
    // shows the reset values before the next edge
    @(posedge CLK_IN);
    RST_B_IN <= 0;
    #1 chk({FLASH_EXT_CLK_OUT, FLASH_FALL_EDGE_OUT, FLASH_ADDR32_OUT,
      FLASH_BUS_WIDTH_OUT, FLASH_OPCODE_OUT, UPSET_DETECT_EN_OUT,
      UPSET_RBCRC_EN_OUT}, 32'h002c);
    @(posedge CLK_IN);
    RST_B_IN <= 1;
    rst_chk();
    $display("second reset done");
    test_done();
  end
endmodule
`default_nettype wire
